// *** src/pmcs_core.sv ***
/*
  Command register set and output supervisor of the power module.
  Assumes requests and telemetry come from logic on clk; fault, on/off and
  aux pins are asynchronous and pass a two-stage synchroniser here.
*/
`default_nettype none
module pmcs_core
  import pmcs_pkg::*;
#(
  parameter logic [7:0] REVISION_CODE = 8'h11, // arbitrary value
  parameter logic [87:0] SERIAL_TEXT = 88'h3030303030303030303030 // arbitrary value
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // command port
  input wire pmcs_req_t req,
  output pmcs_rsp_t rsp,
  input wire logic pec_error,
  // measurement logic
  input wire pmcs_tele_t tele,
  // asynchronous pins
  input wire logic on_off_primary,
  input wire logic vout_ov_pin,
  input wire logic iout_oc_pin,
  input wire logic ot_fault_pin,
  input wire logic ot_warn_pin,
  input wire logic vin_ov_pin,
  input wire logic vin_uv_pin,
  input wire logic power_good_raw,
  // auxiliary configurable pin
  input wire logic aux_pin_in,
  output logic aux_pin_out,
  output logic aux_pin_oe_n,
  // power stage control
  output logic output_enable,
  output logic [1:0] margin_sel
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic shuts_down(input logic [7:0] react);
    shuts_down = react[7:6] != 2'h0;
  endfunction : shuts_down

  function automatic logic [7:0] w1c(input logic [7:0] cur, input logic clr,
                                     input logic [7:0] wd, input logic [7:0] set,
                                     input logic [7:0] mask);
    // set wins over a clear in the same cycle
    w1c = ((cur & ~(clr ? wd : 8'h00)) | set) & mask;
  endfunction : w1c

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser

  logic [8:0] sync1_reg;
  logic [8:0] sync2_reg;
  logic [8:0] pins_raw;
  assign pins_raw = {aux_pin_in, power_good_raw, vin_uv_pin, vin_ov_pin, ot_warn_pin,
                     ot_fault_pin, iout_oc_pin, vout_ov_pin, on_off_primary};

  // two flops before anything reads a pin
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sync1_reg <= 9'h000;
      sync2_reg <= 9'h000;
    end else begin
      sync1_reg <= pins_raw;
      sync2_reg <= sync1_reg;
    end
  end

  logic s_primary, s_vout_ov, s_iout_oc, s_ot_fault, s_ot_warn;
  logic s_vin_ov, s_vin_uv, s_pg, s_aux;
  assign {s_aux, s_pg, s_vin_uv, s_vin_ov, s_ot_warn, s_ot_fault, s_iout_oc, s_vout_ov,
          s_primary} = sync2_reg;

  ////////////////////////////////////////////////////////////////////////////
  // command decode

  logic hit_ctrl, hit_vov, hit_ioc, hit_ot, hit_inp, hit_tmp, hit_cml;
  logic hit_vin, hit_vout, hit_iout, hit_temp, hit_rev, hit_sn;
  logic hit_afn, hit_alg, hit_pgp, hit_any, hit_ro, wr_ok, bad_data;
  assign hit_ctrl = req.code == PMCS_CMD_OUTPUT_CONTROL;
  assign hit_vov = req.code == PMCS_CMD_VOUT_OV_REACT;
  assign hit_ioc = req.code == PMCS_CMD_IOUT_OC_REACT;
  assign hit_ot = req.code == PMCS_CMD_OT_REACT;
  assign hit_inp = req.code == PMCS_CMD_INPUT_FLAGS;
  assign hit_tmp = req.code == PMCS_CMD_TEMP_FLAGS;
  assign hit_cml = req.code == PMCS_CMD_COMM_FLAGS;
  assign hit_vin = req.code == PMCS_CMD_VIN_READ;
  assign hit_vout = req.code == PMCS_CMD_VOUT_READ;
  assign hit_iout = req.code == PMCS_CMD_IOUT_READ;
  assign hit_temp = req.code == PMCS_CMD_TEMP_READ;
  assign hit_rev = req.code == PMCS_CMD_REVISION;
  assign hit_sn = req.code == PMCS_CMD_SERIAL;
  assign hit_afn = req.code == PMCS_CMD_AUX_FUNC;
  assign hit_alg = req.code == PMCS_CMD_AUX_LOGIC;
  assign hit_pgp = req.code == PMCS_CMD_PG_POLARITY;
  assign hit_any = hit_ctrl | hit_vov | hit_ioc | hit_ot | hit_inp | hit_tmp | hit_cml |
                   hit_vin | hit_vout | hit_iout | hit_temp | hit_rev | hit_sn |
                   hit_afn | hit_alg | hit_pgp;
  // reaction bytes and readbacks refuse writes
  assign hit_ro = hit_vov | hit_ioc | hit_ot | hit_vin | hit_vout | hit_iout | hit_temp |
                  hit_rev | hit_sn;
  // margin code 11 is not defined and is refused as bad data
  assign bad_data = req.wr & hit_ctrl & (req.wdata[5:4] == 2'h3);
  assign wr_ok = req.wr & hit_any & ~hit_ro & ~bad_data;

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers

  logic [7:0] ctrl_reg, vov_reg, ioc_reg, ot_reg, afn_reg, alg_reg, pgp_reg;

  // reaction bytes have no write path at all
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ctrl_reg <= PMCS_RST_OUTPUT_CONTROL;
      vov_reg <= PMCS_RST_VOUT_OV_REACT;
      ioc_reg <= PMCS_RST_IOUT_OC_REACT;
      ot_reg <= PMCS_RST_OT_REACT;
      afn_reg <= PMCS_RST_AUX_FUNC;
      alg_reg <= PMCS_RST_AUX_LOGIC;
      pgp_reg <= PMCS_RST_PG_POLARITY;
    end else begin
      if (wr_ok && hit_ctrl) begin
        ctrl_reg <= req.wdata[7:0] & PMCS_CTRL_WRITABLE;
      end
      if (wr_ok && hit_afn) begin
        afn_reg <= req.wdata[7:0];
      end
      if (wr_ok && hit_alg) begin
        alg_reg <= req.wdata[7:0];
      end
      if (wr_ok && hit_pgp) begin
        pgp_reg <= req.wdata[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status flags, write one to clear

  logic [7:0] inp_reg, tmp_reg, cml_reg, inp_set, tmp_set, cml_set;
  assign inp_set = {s_vin_ov, 2'h0, s_vin_uv, 4'h0};
  assign tmp_set = {s_ot_fault, s_ot_warn, 6'h00};
  assign cml_set = {req.rd | req.wr ? ~hit_any | (req.wr & hit_ro) : 1'b0,
                    bad_data, pec_error, 5'h00};

  always_ff @(posedge clk) begin
    if (!resetn) begin
      inp_reg <= 8'h00;
      tmp_reg <= 8'h00;
      cml_reg <= 8'h00;
    end else begin
      inp_reg <= w1c(inp_reg, req.wr & hit_inp, req.wdata[7:0], inp_set,
                     PMCS_INPUT_FLAG_MASK);
      tmp_reg <= w1c(tmp_reg, req.wr & hit_tmp, req.wdata[7:0], tmp_set,
                     PMCS_TEMP_FLAG_MASK);
      cml_reg <= w1c(cml_reg, req.wr & hit_cml, req.wdata[7:0], cml_set,
                     PMCS_COMM_FLAG_MASK);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // telemetry capture; mantissas arrive already scaled by the fixed exponent

  pmcs_tele_t tele_reg;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      tele_reg <= '0;
    end else begin
      tele_reg <= tele;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux and answer

  logic [7:0] sn_byte;
  logic sn_ok;
  logic [15:0] rd_data;
  logic [3:0] rd_len;
  // first character of the string is sent first
  assign sn_byte = SERIAL_TEXT[8'(87 - 8 * int'(req.idx)) -: 8];
  assign sn_ok = req.idx < PMCS_SERIAL_LEN;
  assign rd_data =
    hit_ctrl ? {8'h00, ctrl_reg} :
    hit_vov ? {8'h00, vov_reg} :
    hit_ioc ? {8'h00, ioc_reg} :
    hit_ot ? {8'h00, ot_reg} :
    hit_inp ? {8'h00, inp_reg} :
    hit_tmp ? {8'h00, tmp_reg} :
    hit_cml ? {8'h00, cml_reg} :
    hit_vin ? tele_reg.vin :
    hit_vout ? tele_reg.vout :
    hit_iout ? tele_reg.iout :
    hit_temp ? tele_reg.temp :
    hit_rev ? {8'h00, REVISION_CODE} :
    hit_sn ? {8'h00, sn_byte} :
    hit_afn ? {8'h00, afn_reg} :
    hit_alg ? {8'h00, alg_reg} :
    hit_pgp ? {8'h00, pgp_reg} : 16'h0000;
  assign rd_len = hit_sn ? PMCS_SERIAL_LEN :
                  (hit_vin | hit_vout | hit_iout | hit_temp) ? PMCS_LEN_WORD :
                  PMCS_LEN_BYTE;

  pmcs_rsp_t rsp_next;
  always_comb begin
    rsp_next = '0;
    rsp_next.valid = req.rd | req.wr;
    if (req.rd) begin
      rsp_next.nak = ~hit_any | (hit_sn & ~sn_ok);
      rsp_next.len = rd_len;
      rsp_next.data = (hit_any && !(hit_sn && !sn_ok)) ? rd_data : 16'h0000;
    end else if (req.wr) begin
      rsp_next.nak = ~wr_ok & ~(hit_inp | hit_tmp | hit_cml);
    end
  end

  // answer is a registered one-cycle pulse
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rsp <= '0;
    end else begin
      rsp <= rsp_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // enable request and fault trip

  logic aux_is_pg, aux_is_sec, sec_ok, enable_req;
  logic trip_vov, trip_ioc, trip_ot, trip_any, trip_latch;
  assign aux_is_pg = afn_reg[3:0] == PMCS_AUX_POWER_GOOD;
  assign aux_is_sec = afn_reg[3:0] == PMCS_AUX_SECONDARY_ONOFF;
  // secondary input only matters when mapped and the and mode is chosen
  assign sec_ok = ~(aux_is_sec & alg_reg[PMCS_AUX_AND_BIT]) | s_aux;
  assign enable_req = ctrl_reg[PMCS_CTRL_ENABLE_BIT] & s_primary & sec_ok;
  assign trip_vov = s_vout_ov & shuts_down(vov_reg);
  assign trip_ioc = s_iout_oc & shuts_down(ioc_reg);
  assign trip_ot = s_ot_fault & shuts_down(ot_reg);
  assign trip_any = trip_vov | trip_ioc | trip_ot;
  // any tripping fault set to no retry holds the unit off
  assign trip_latch = (trip_vov & (vov_reg[5:3] == PMCS_RETRY_NONE)) |
                      (trip_ioc & (ioc_reg[5:3] == PMCS_RETRY_NONE)) |
                      (trip_ot & (ot_reg[5:3] == PMCS_RETRY_NONE));

  ////////////////////////////////////////////////////////////////////////////
  // output supervisor

  typedef enum logic [3:0] {
    PMCS_ST_OFF = 4'h1,
    PMCS_ST_ON = 4'h2,
    PMCS_ST_WAIT = 4'h4,
    PMCS_ST_LATCH = 4'h8
  } pmcs_state_t;

  pmcs_state_t state_reg, state_next;
  logic [7:0] wait_reg, wait_next;

  always_comb begin
    state_next = state_reg;
    wait_next = wait_reg;
    case (state_reg)
      PMCS_ST_OFF: begin
        if (enable_req && !trip_any) begin
          state_next = PMCS_ST_ON;
        end
      end
      PMCS_ST_ON: begin
        if (!enable_req) begin
          state_next = PMCS_ST_OFF;
        end else if (trip_latch) begin
          state_next = PMCS_ST_LATCH;
        end else if (trip_any) begin
          state_next = PMCS_ST_WAIT;
          wait_next = PMCS_RESTART_CYCLES;
        end
      end
      PMCS_ST_WAIT: begin
        // hiccup: retry each interval until commanded off
        if (!enable_req) begin
          state_next = PMCS_ST_OFF;
        end else if (wait_reg == 8'h01) begin
          state_next = PMCS_ST_ON;
        end else begin
          wait_next = wait_reg - 8'h01;
        end
      end
      PMCS_ST_LATCH: begin
        // only a command off clears a latched trip
        if (!enable_req) begin
          state_next = PMCS_ST_OFF;
        end
      end
      default: begin
        state_next = PMCS_ST_OFF;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_reg <= PMCS_ST_OFF;
      wait_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      wait_reg <= wait_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  logic pg_level;
  assign pg_level = s_pg ~^ pgp_reg[0];

  always_ff @(posedge clk) begin
    if (!resetn) begin
      output_enable <= 1'b0;
      margin_sel <= PMCS_MARGIN_NONE;
      aux_pin_out <= 1'b0;
      aux_pin_oe_n <= 1'b1;
    end else begin
      output_enable <= state_next == PMCS_ST_ON;
      margin_sel <= ctrl_reg[5:4];
      aux_pin_out <= aux_is_pg & pg_level;
      aux_pin_oe_n <= ~aux_is_pg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_tripped;
    state_reg == PMCS_ST_ON && enable_req && trip_any && !trip_latch;
  endsequence

  sequence s_off_wait;
    !output_enable [*8];
  endsequence

  chk_ctrl_write_lands: assert property (
    wr_ok && hit_ctrl |=> ctrl_reg == ($past(req.wdata[7:0]) & PMCS_CTRL_WRITABLE))
    else $error("control byte write not stored");
  chk_react_read_only: assert property (
    $stable(vov_reg) && $stable(ioc_reg) && $stable(ot_reg))
    else $error("reaction byte changed");
  chk_hiccup_restart: assert property (
    s_tripped |=> s_off_wait ##[1:120] (output_enable || !enable_req))
    else $error("hiccup restart missing or early");
  chk_latch_holds: assert property (
    state_reg == PMCS_ST_LATCH && enable_req |=> !output_enable)
    else $error("latched trip restarted");
  chk_input_flag_sets: assert property (
    s_vin_ov |=> inp_reg[7])
    else $error("input overvoltage flag not set");
  chk_temp_readback: assert property (
    req.rd && hit_tmp |=> rsp.valid && rsp.data[7:0] == $past(tmp_reg))
    else $error("temperature flags misread");
  chk_comm_unknown: assert property (
    req.rd && !hit_any |=> rsp.nak && cml_reg[7])
    else $error("unknown command not flagged");
  chk_vout_readback: assert property (
    req.rd && hit_vout |=> rsp.data == $past(tele_reg.vout) && rsp.len == PMCS_LEN_WORD)
    else $error("output voltage word misread");
  chk_serial_length: assert property (
    req.rd && hit_sn |=> rsp.len == PMCS_SERIAL_LEN && rsp.nak == ($past(req.idx) > 4'hA))
    else $error("serial block length wrong");
  chk_and_mode: assert property (
    aux_is_sec && alg_reg[PMCS_AUX_AND_BIT] && !s_aux |=> !output_enable)
    else $error("secondary input ignored in and mode");
  chk_pg_drive: assert property (
    aux_is_pg |=> !aux_pin_oe_n && aux_pin_out == $past(pg_level))
    else $error("aux pin not driving power good");

endmodule : pmcs_core
`default_nettype wire

// *** include/pmcs_pkg.sv ***
/*
  Constants, command codes, field layouts and carrier types of the power module
  command set. Assumes a transaction layer in front of the core that turns bus
  frames into one-cycle command requests on the core clock.
*/
// Behaviour
// - control byte resets to 80; bit7 enables output, bits5:4 pick margin mode.
// - voltage reaction byte defaults B8: shut down, follow retry, no delay.
// - retry field 111 restarts repeatedly while fault persists until commanded off.
// - retry field 000 keeps the unit off after a fault, no restart.
// - current reaction byte defaults F8: shut down, retry 111, no delay.
// - temperature reaction byte defaults B8: shut down, retry 111, no delay.
// - code 7C answers input over and under voltage fault flags.
// - code 7D answers temperature fault and warning flags.
// - code 7E answers communication fault flags.
// - code 88 returns input voltage word, exponent -3.
// - code 8B returns output voltage word, exponent -12.
// - code 8C returns output current word, exponent -4.
// - code 8D returns hot spot temperature word, exponent -2.
// - code 98 returns a fixed read-only protocol revision byte.
// - code E0 is a read/write aux pin function byte resetting to 00.
// - code E2 is a read/write power good polarity byte, default 01.
// - block read at 9E returns exactly eleven serial number characters.
// - aux function 0000 drives power good, 0010 makes a secondary on/off input.
// - aux logic bit1 clear ignores secondary input; set requires both inputs.
`default_nettype none
package pmcs_pkg;
  // command codes
  localparam logic [7:0] PMCS_CMD_OUTPUT_CONTROL = 8'h01;
  localparam logic [7:0] PMCS_CMD_VOUT_OV_REACT = 8'h41;
  localparam logic [7:0] PMCS_CMD_IOUT_OC_REACT = 8'h47;
  localparam logic [7:0] PMCS_CMD_OT_REACT = 8'h50;
  localparam logic [7:0] PMCS_CMD_INPUT_FLAGS = 8'h7C;
  localparam logic [7:0] PMCS_CMD_TEMP_FLAGS = 8'h7D;
  localparam logic [7:0] PMCS_CMD_COMM_FLAGS = 8'h7E;
  localparam logic [7:0] PMCS_CMD_VIN_READ = 8'h88;
  localparam logic [7:0] PMCS_CMD_VOUT_READ = 8'h8B;
  localparam logic [7:0] PMCS_CMD_IOUT_READ = 8'h8C;
  localparam logic [7:0] PMCS_CMD_TEMP_READ = 8'h8D;
  localparam logic [7:0] PMCS_CMD_REVISION = 8'h98;
  localparam logic [7:0] PMCS_CMD_SERIAL = 8'h9E;
  localparam logic [7:0] PMCS_CMD_AUX_FUNC = 8'hE0;
  localparam logic [7:0] PMCS_CMD_AUX_LOGIC = 8'hE1;
  localparam logic [7:0] PMCS_CMD_PG_POLARITY = 8'hE2;
  // reset values
  localparam logic [7:0] PMCS_RST_OUTPUT_CONTROL = 8'h80;
  localparam logic [7:0] PMCS_RST_VOUT_OV_REACT = 8'hB8;
  localparam logic [7:0] PMCS_RST_IOUT_OC_REACT = 8'hF8;
  localparam logic [7:0] PMCS_RST_OT_REACT = 8'hB8;
  localparam logic [7:0] PMCS_RST_AUX_FUNC = 8'h00;
  localparam logic [7:0] PMCS_RST_AUX_LOGIC = 8'h00;
  localparam logic [7:0] PMCS_RST_PG_POLARITY = 8'h01;
  // field positions and encodings
  localparam int PMCS_CTRL_ENABLE_BIT = 7;
  localparam logic [7:0] PMCS_CTRL_WRITABLE = 8'hB0;
  localparam logic [1:0] PMCS_MARGIN_NONE = 2'h0;
  localparam logic [1:0] PMCS_MARGIN_LOW = 2'h1;
  localparam logic [1:0] PMCS_MARGIN_HIGH = 2'h2;
  localparam logic [2:0] PMCS_RETRY_FOREVER = 3'h7;
  localparam logic [2:0] PMCS_RETRY_NONE = 3'h0;
  localparam logic [3:0] PMCS_AUX_POWER_GOOD = 4'h0;
  localparam logic [3:0] PMCS_AUX_SECONDARY_ONOFF = 4'h2;
  localparam int PMCS_AUX_AND_BIT = 1;
  localparam logic [7:0] PMCS_INPUT_FLAG_MASK = 8'h90;
  localparam logic [7:0] PMCS_TEMP_FLAG_MASK = 8'hC0;
  localparam logic [7:0] PMCS_COMM_FLAG_MASK = 8'hE0;
  localparam logic [3:0] PMCS_SERIAL_LEN = 4'hB;
  localparam logic [3:0] PMCS_LEN_BYTE = 4'h1;
  localparam logic [3:0] PMCS_LEN_WORD = 4'h2;
  // timing
  localparam int PMCS_CLK_PERIOD_NS = 10;
  localparam int PMCS_RESTART_NS = 1000;
  localparam logic [7:0] PMCS_RESTART_CYCLES =
    8'((PMCS_RESTART_NS + PMCS_CLK_PERIOD_NS - 1) / PMCS_CLK_PERIOD_NS);
  // one command request from the transaction layer
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] code;
    logic [3:0] idx;
    logic [15:0] wdata;
  } pmcs_req_t;
  // answer to a request, one cycle later
  typedef struct packed {
    logic valid;
    logic nak;
    logic [3:0] len;
    logic [15:0] data;
  } pmcs_rsp_t;
  // telemetry mantissas, exponents fixed per command
  typedef struct packed {
    logic [15:0] vin;
    logic [15:0] vout;
    logic [15:0] iout;
    logic [15:0] temp;
  } pmcs_tele_t;
endpackage : pmcs_pkg
`default_nettype wire

// *** tb/pmcs_host_model.sv ***
/*
  host controller model for the command set core: issues one request at a
  time on the command port and captures the answer.
  assumes the core answers on the taking edge itself.
*/
`default_nettype none
module pmcs_host_model
  import pmcs_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // command port of the core
  output pmcs_req_t req,
  input wire pmcs_rsp_t rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  pmcs_rsp_t got;
  logic got_ok;
  //////////////////////////////////////////////////////////////////////
  // one request held for a single edge; bounded wait for the answer
  task automatic xfer(input pmcs_req_t r);
    int n;
    got_ok = 1'b0;
    got = '0;
    @(posedge clk);
    req <= r;
    @(posedge clk);
    // released fields show the inverse, so a stale capture cannot match
    req <= {2'b00, ~r[27:0]};
    // the answer stands only from the taking edge to the next one
    for (n = 0; n < 4 && !got_ok; n++) begin
      #1;
      if (rsp.valid === 1'b1) begin
        got = rsp;
        got_ok = 1'b1;
      end else begin
        @(posedge clk);
      end
    end
  endtask : xfer
  // idle until the first transfer
  initial req = '0;
endmodule : pmcs_host_model
`default_nettype wire

// *** tb/pmbus_power_module_command_set_test.sv ***
/*
  self-checking bench of the command set core: table of register accesses,
  then margin, aux pin, fault restart, status flag and reset cases.
  assumes the host model drives the command port; pins are driven here.
*/
`default_nettype none
module pmbus_power_module_command_set_test
  import pmcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] code;
    logic [3:0] idx;
    logic [15:0] wdata;
    logic nak;
    logic [3:0] len;
    logic [15:0] data;
  } pmcs_row_t;
  logic clk, resetn, pec_error, on_off_primary, vout_ov_pin, iout_oc_pin, ot_fault_pin;
  logic ot_warn_pin, vin_ov_pin, vin_uv_pin, power_good_raw, aux_pin_in;
  logic aux_pin_out, aux_pin_oe_n, output_enable;
  logic [1:0] margin_sel;
  pmcs_req_t req;
  pmcs_rsp_t rsp;
  pmcs_tele_t tele;
  int mismatches = 0;
  int checks_done = 0;
  //////////////////////////////////////////////////////////////////////
  // revision and serial text are arbitrary values
  pmcs_core #(.REVISION_CODE(8'h5A), .SERIAL_TEXT(88'h4142313233343536373839)) i_dut (
    .clk(clk), .resetn(resetn), .req(req), .rsp(rsp), .pec_error(pec_error),
    .tele(tele), .on_off_primary(on_off_primary), .vout_ov_pin(vout_ov_pin),
    .iout_oc_pin(iout_oc_pin), .ot_fault_pin(ot_fault_pin), .ot_warn_pin(ot_warn_pin),
    .vin_ov_pin(vin_ov_pin), .vin_uv_pin(vin_uv_pin), .power_good_raw(power_good_raw),
    .aux_pin_in(aux_pin_in), .aux_pin_out(aux_pin_out), .aux_pin_oe_n(aux_pin_oe_n),
    .output_enable(output_enable), .margin_sel(margin_sel));
  pmcs_host_model i_host (.clk(clk), .resetn(resetn), .req(req), .rsp(rsp));
  //////////////////////////////////////////////////////////////////////
  // rd, wr, code, idx, wdata, nak, len (0 = not checked), data
  pmcs_row_t rows[] = '{
    '{1, 0, 8'h01, 4'h0, 16'h0, 0, 4'h1, 16'h0080},
    '{1, 0, 8'h41, 4'h0, 16'h0, 0, 4'h1, 16'h00B8},
    '{1, 0, 8'h47, 4'h0, 16'h0, 0, 4'h1, 16'h00F8},
    '{1, 0, 8'h50, 4'h0, 16'h0, 0, 4'h1, 16'h00B8},
    '{1, 0, 8'h98, 4'h0, 16'h0, 0, 4'h1, 16'h005A},
    '{1, 0, 8'hE0, 4'h0, 16'h0, 0, 4'h1, 16'h0000},
    '{1, 0, 8'hE1, 4'h0, 16'h0, 0, 4'h1, 16'h0000},
    '{1, 0, 8'hE2, 4'h0, 16'h0, 0, 4'h1, 16'h0001},
    '{1, 0, 8'h88, 4'h0, 16'h0, 0, 4'h2, 16'h0180},
    '{1, 0, 8'h8B, 4'h0, 16'h0, 0, 4'h2, 16'hC000},
    '{1, 0, 8'h8C, 4'h0, 16'h0, 0, 4'h2, 16'h0190},
    '{1, 0, 8'h8D, 4'h0, 16'h0, 0, 4'h2, 16'h00C8},
    '{1, 0, 8'h7C, 4'h0, 16'h0, 0, 4'h1, 16'h0000},
    '{1, 0, 8'h9E, 4'h0, 16'h0, 0, 4'hB, 16'h0041},
    '{1, 0, 8'h9E, 4'hA, 16'h0, 0, 4'hB, 16'h0039},
    '{1, 0, 8'h9E, 4'hB, 16'h0, 1, 4'h0, 16'h0000},
    '{0, 1, 8'h41, 4'h0, 16'h0, 1, 4'h0, 16'h0000},
    '{0, 1, 8'h47, 4'h0, 16'h0, 1, 4'h0, 16'h0000},
    '{0, 1, 8'h50, 4'h0, 16'h0, 1, 4'h0, 16'h0000},
    '{1, 0, 8'h47, 4'h0, 16'h0, 0, 4'h1, 16'h00F8},
    '{0, 1, 8'h01, 4'h0, 16'h0030, 1, 4'h0, 16'h0000},
    '{0, 1, 8'h01, 4'h0, 16'h0090, 0, 4'h0, 16'h0000},
    '{1, 0, 8'h01, 4'h0, 16'h0, 0, 4'h1, 16'h0090},
    '{0, 1, 8'hE0, 4'h0, 16'h0005, 0, 4'h0, 16'h0000},
    '{1, 0, 8'hE0, 4'h0, 16'h0, 0, 4'h1, 16'h0005},
    '{0, 1, 8'hE0, 4'h0, 16'h0000, 0, 4'h0, 16'h0000},
    '{1, 0, 8'h03, 4'h0, 16'h0, 1, 4'h0, 16'h0000},
    '{1, 0, 8'h7E, 4'h0, 16'h0, 0, 4'h1, 16'h00C0},
    '{0, 1, 8'h7E, 4'h0, 16'h00FF, 0, 4'h0, 16'h0000},
    '{1, 0, 8'h7E, 4'h0, 16'h0, 0, 4'h1, 16'h0000}};
  //////////////////////////////////////////////////////////////////////
  // comparison, counted and reported at once
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("wrong value at %0d ns: got %h, expected %h", $time, got, exp);
      mismatches++;
    end
  endtask : check
  // one access through the host, answer compared field by field
  task automatic run(input pmcs_row_t r);
    i_host.xfer({r.rd, r.wr, r.code, r.idx, r.wdata});
    check(16'(i_host.got_ok), 16'h0001);
    check(16'(i_host.got.nak), 16'(r.nak));
    check(i_host.got.data, r.data);
    if (r.len != 4'h0) check(16'(i_host.got.len), 16'(r.len));
  endtask : run
  // bounded wait for the power stage to reach a level
  task automatic wait_oe(input logic exp, input int lim);
    int n;
    for (n = 0; n < lim && output_enable !== exp; n++) begin
      @(posedge clk);
      #1;
    end
    check(16'(output_enable), 16'(exp));
  endtask : wait_oe
  task automatic end_sim();
    if (mismatches == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim
  //////////////////////////////////////////////////////////////////////
  // clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // watchdog: the sequence needs well under 2000 cycles
  initial begin
    #200000;
    mismatches++;
    end_sim();
  end
  // main sequence
  initial begin
    {resetn, pec_error, vout_ov_pin, iout_oc_pin, ot_fault_pin} = 5'h00;
    {ot_warn_pin, vin_ov_pin, vin_uv_pin} = 3'h0;
    {on_off_primary, power_good_raw, aux_pin_in} = 3'h7;
    // 48 V, 12 V, 25 A, 50 C over two to the fixed exponent
    tele = '{16'h0180, 16'hC000, 16'h0190, 16'h00C8};
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    #1 check(16'(rsp.valid), 16'h0000);
    check(16'(aux_pin_oe_n), 16'h0001);
    @(posedge clk);
    #1 check(16'(output_enable), 16'h0000);
    wait_oe(1'b1, 8);
    foreach (rows[i]) run(rows[i]);
    check(16'(margin_sel), 16'(PMCS_MARGIN_LOW));
    run('{0, 1, 8'h01, 4'h0, 16'h0020, 0, 4'h0, 16'h0});
    wait_oe(1'b0, 4);
    check(16'(margin_sel), 16'(PMCS_MARGIN_HIGH));
    run('{0, 1, 8'h01, 4'h0, 16'h0080, 0, 4'h0, 16'h0});
    wait_oe(1'b1, 8);
    // aux pin as power good output, then inverted polarity
    check(16'(aux_pin_out), 16'h0001);
    check(16'(aux_pin_oe_n), 16'h0000);
    run('{0, 1, 8'hE2, 4'h0, 16'h0000, 0, 4'h0, 16'h0});
    repeat (3) @(posedge clk);
    #1 check(16'(aux_pin_out), 16'h0000);
    run('{0, 1, 8'hE2, 4'h0, 16'h0001, 0, 4'h0, 16'h0});
    // aux pin as secondary on/off input, and-ed with the primary
    run('{0, 1, 8'hE0, 4'h0, 16'h0002, 0, 4'h0, 16'h0});
    run('{0, 1, 8'hE1, 4'h0, 16'h0002, 0, 4'h0, 16'h0});
    @(posedge clk);
    aux_pin_in <= 1'b0;
    wait_oe(1'b0, 8);
    check(16'(aux_pin_oe_n), 16'h0001);
    @(posedge clk);
    aux_pin_in <= 1'b1;
    wait_oe(1'b1, 8);
    run('{0, 1, 8'hE1, 4'h0, 16'h0000, 0, 4'h0, 16'h0});
    run('{0, 1, 8'hE0, 4'h0, 16'h0000, 0, 4'h0, 16'h0});
    // persistent fault holds it off between hiccup retries; restart after the fault clears
    @(posedge clk);
    vout_ov_pin <= 1'b1;
    wait_oe(1'b0, 8);
    repeat (150) @(posedge clk);
    #1 check(16'(output_enable), 16'h0000);
    @(posedge clk);
    vout_ov_pin <= 1'b0;
    wait_oe(1'b1, 120);
    // sticky flags from pins and a checksum error pulse
    @(posedge clk);
    {ot_fault_pin, ot_warn_pin, vin_ov_pin, vin_uv_pin, iout_oc_pin, pec_error} <= 6'h3F;
    @(posedge clk);
    pec_error <= 1'b0;
    repeat (4) @(posedge clk);
    {ot_fault_pin, ot_warn_pin, vin_ov_pin, vin_uv_pin, iout_oc_pin} <= 5'h00;
    run('{1, 0, 8'h7C, 4'h0, 16'h0, 0, 4'h1, 16'h0090});
    run('{1, 0, 8'h7D, 4'h0, 16'h0, 0, 4'h1, 16'h00C0});
    run('{1, 0, 8'h7E, 4'h0, 16'h0, 0, 4'h1, 16'h0020});
    wait_oe(1'b1, 120);
    // second reset in mid-run restores defaults and clears flags
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    #1 check(16'(output_enable), 16'h0000);
    run('{1, 0, 8'h01, 4'h0, 16'h0, 0, 4'h1, 16'h0080});
    run('{1, 0, 8'h7D, 4'h0, 16'h0, 0, 4'h1, 16'h0000});
    end_sim();
  end
endmodule : pmbus_power_module_command_set_test
`default_nettype wire
